// ---- hw/pss_pkg.sv ----
// Purpose: shared constants and types for the program sequencer
// Assumes: 8-bit data memory map, 14-bit program words
// Notes: vectors and offsets are fixed by the instruction set
package pss_pkg;
   localparam int PC_W = 11;
   localparam int ROM_WORDS = 2048;
   localparam int ROM_W = 14;
   localparam int DATA_W = 8;
   localparam int MEM_AW = 7;
   localparam int STK_DEPTH = 4;
   localparam int STK_CNT_W = 3;
   localparam int IRQ_N = 5;
   localparam int PHASES = 4;
   localparam int TBL_CYCLES = 2;

   localparam logic [MEM_AW-1:0] OFS_PC_LOW = 7'h06;
   localparam logic [MEM_AW-1:0] OFS_TBL_PTR = 7'h07;
   localparam logic [MEM_AW-1:0] OFS_TBL_HIGH = 7'h08;

   localparam logic [PC_W-1:0] PC_RESET = 11'h000;
   localparam logic [PC_W-1:0] VEC_EXT_A = 11'h004;
   localparam logic [PC_W-1:0] VEC_EXT_B = 11'h008;
   localparam logic [PC_W-1:0] VEC_TIMER = 11'h00C;
   localparam logic [PC_W-1:0] VEC_TIME_BASE = 11'h010;
   localparam logic [PC_W-1:0] VEC_RTC = 11'h014;
   localparam logic [2:0] LAST_PAGE = 3'h7;

   localparam logic [DATA_W-1:0] TBL_PTR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] TBL_HIGH_RESET = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_JUMP = 3'h1,
      OP_CALL = 3'h2,
      OP_SUBROUTINE_RETURN = 3'h3,
      OP_INTERRUPT_RETURN = 3'h4,
      OP_SKIP = 3'h5,
      OP_TABLE_READ_CURRENT_PAGE = 3'h6,
      OP_TABLE_READ_LAST_PAGE = 3'h7
   } pss_op_type;

   // one decoded instruction, valid while exec_valid is high
   typedef struct packed {
      pss_op_type op;
      logic [PC_W-1:0] target;
      logic skip_true;
   } pss_cmd_type;

   typedef enum logic [3:0] {
      PH_FETCH = 4'h1,
      PH_DECODE = 4'h2,
      PH_EXEC = 4'h4,
      PH_WRITE = 4'h8
   } pss_phase_type;
endpackage

// ---- hw/pss_return_stack.sv ----
// Purpose: circular return-address stack
// Assumes: push and pop never in the same cycle
// Notes: push when full overwrites the oldest entry
`timescale 1ns/10ps
module pss_return_stack #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 11,
   parameter int CNT_W = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top_data,
   output logic full,
   output logic [CNT_W-1:0] level
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW-1:0] PTR_MAX = PW'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] ptr_q;
   logic [CNT_W-1:0] cnt_q;
   logic [PW-1:0] below;

   assign below = (ptr_q == '0) ? PTR_MAX : ptr_q - 1'b1;
   assign top_data = mem_q[below];
   assign full = (cnt_q == CNT_MAX);
   assign level = cnt_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (push) begin
         mem_q[ptr_q] <= push_data;
      end
   end

   // reset leaves the index at the top of an empty stack
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr_q <= '0;
         cnt_q <= '0;
      end else if (push) begin
         ptr_q <= (ptr_q == PTR_MAX) ? '0 : ptr_q + 1'b1;
         cnt_q <= full ? cnt_q : cnt_q + 1'b1;
      end else if (pop && cnt_q != '0) begin
         ptr_q <= below;
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // pss_return_stack

// ---- hw/pss_sequencer.sv ----
// Purpose: program counter, fetch pipeline, table reads, return stack
// Assumes: decode presents cmd for instr_word while exec_valid is high
// Notes: apart from the phase counter and the tbl_wr strobe, state changes happen on cycle_end, the last phase
`timescale 1ns/10ps
// Function
// - program counter is 11 bits wide, reaching all 2048 words.
// - counter steps by one after every instruction fetch.
// - true skip discards the prefetched word, inserting a dummy cycle.
// - write to low-byte register replaces bits 7..0, keeps 10..8.
// - reset clears the counter to 000H.
// - enabled first external interrupt loads 004H when stack not full.
// - enabled second external interrupt loads 008H when stack not full.
// - enabled timer overflow interrupt loads 00CH when stack not full.
// - enabled time base interrupt loads 010H when stack not full.
// - enabled real time clock interrupt loads 014H when stack not full.
// - jump and call load all eleven bits from the instruction.
// - every counter reload costs one extra dummy cycle.
// - program memory is 2048 by 14, addressed by counter or table.
// - current-page table read uses counter bits 10..8 plus pointer.
// - last-page table read forces upper three address bits to ones.
// - table low byte to data memory, upper six to high-byte register.
// - high-byte register read-only; pointer at 07H read and write.
// - each table read takes two instruction cycles.
// - four-level return stack, hidden from software.
// - call or interrupt pushes counter; returns restore it.
// - reset sets the stack index to the top of the stack.
// - full stack holds pending interrupts until a return pops.
// - call on a full stack overwrites the oldest entry.
// - four clocks per instruction cycle, fetch overlapping execute.
module pss_sequencer (
   input wire logic clk,
   input wire logic rstn,
   output logic [pss_pkg::PC_W-1:0] rom_addr,
   input wire logic [pss_pkg::ROM_W-1:0] rom_data,
   output logic [pss_pkg::ROM_W-1:0] instr_word,
   output logic exec_valid,
   output logic cycle_end,
   input wire pss_pkg::pss_cmd_type cmd,
   input wire logic [pss_pkg::MEM_AW-1:0] mem_addr,
   input wire logic mem_wr,
   input wire logic [pss_pkg::DATA_W-1:0] mem_wdata,
   output logic [pss_pkg::DATA_W-1:0] mem_rdata,
   output logic mem_hit,
   output logic tbl_wr,
   output logic [pss_pkg::DATA_W-1:0] tbl_wr_data,
   input wire logic [pss_pkg::IRQ_N-1:0] irq_req,
   output logic [pss_pkg::IRQ_N-1:0] irq_ack,
   output logic [pss_pkg::PC_W-1:0] instruction_pointer,
   output logic stack_full,
   output logic [pss_pkg::STK_CNT_W-1:0] stack_index
);
   import pss_pkg::*;

   pss_phase_type phase_q;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [ROM_W-1:0] instr_q;
   logic instr_valid_q;
   logic tbl_busy_q;
   logic tbl_last_q;
   logic [DATA_W-1:0] tbl_ptr_q;
   logic [DATA_W-1:0] tbl_high_q;
   logic tbl_wr_q;
   logic [DATA_W-1:0] tbl_wr_data_q;
   logic [PC_W-1:0] tbl_addr;
   logic [PC_W-1:0] stack_top;
   logic [PC_W-1:0] vec;
   logic [IRQ_N-1:0] irq_pick;
   logic last;
   logic do_jump;
   logic do_call;
   logic do_ret;
   logic do_skip;
   logic do_tbl;
   logic pcl_wr;
   logic table_pointer_wr;
   logic busy_xfer;
   logic take_irq;
   logic push;
   logic pop;

   // ---------------- instruction cycle phases
   assign last = (phase_q == PH_WRITE);
   assign cycle_end = last;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= PH_FETCH;
      end else begin
         case (phase_q)
            PH_FETCH: phase_q <= PH_DECODE;
            PH_DECODE: phase_q <= PH_EXEC;
            PH_EXEC: phase_q <= PH_WRITE;
            PH_WRITE: phase_q <= PH_FETCH;
            default: phase_q <= PH_FETCH;
         endcase
      end
   end

   // ---------------- decoded control for the executing slot
   // a dummy slot or the second table cycle ignores whatever decode shows
   assign exec_valid = instr_valid_q && !tbl_busy_q;
   assign do_jump = exec_valid && cmd.op == OP_JUMP;
   assign do_call = exec_valid && cmd.op == OP_CALL;
   assign do_ret = exec_valid
      && (cmd.op == OP_SUBROUTINE_RETURN || cmd.op == OP_INTERRUPT_RETURN);
   assign do_skip = exec_valid && cmd.op == OP_SKIP && cmd.skip_true;
   assign do_tbl = exec_valid
      && (cmd.op == OP_TABLE_READ_CURRENT_PAGE || cmd.op == OP_TABLE_READ_LAST_PAGE);
   assign pcl_wr = mem_wr && mem_addr == OFS_PC_LOW;
   assign table_pointer_wr = mem_wr && mem_addr == OFS_TBL_PTR;
   assign busy_xfer = do_jump || do_call || do_ret || do_skip || do_tbl
      || pcl_wr || tbl_busy_q;

   // ---------------- interrupt acknowledge
   // lowest request index wins; enable and flag logic sit outside
   always_comb begin
      irq_pick = '0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_pick = '0;
            irq_pick[i] = 1'b1;
         end
      end
   end

   always_comb begin
      case (irq_pick)
         5'h01: vec = VEC_EXT_A;
         5'h02: vec = VEC_EXT_B;
         5'h04: vec = VEC_TIMER;
         5'h08: vec = VEC_TIME_BASE;
         5'h10: vec = VEC_RTC;
         default: vec = PC_RESET;
      endcase
   end

   // full stack: request stays pending outside until a return frees a slot
   assign take_irq = last && (|irq_req) && !stack_full && !busy_xfer;
   assign irq_ack = take_irq ? irq_pick : '0;

   // ---------------- return stack
   // pc_q already holds the address after the executing word
   assign push = last && (do_call || take_irq);
   assign pop = last && do_ret;

   pss_return_stack #(
      .DEPTH(STK_DEPTH),
      .WIDTH(PC_W),
      .CNT_W(STK_CNT_W)
   ) u_stack (
      .clk(clk),
      .rstn(rstn),
      .push(push),
      .pop(pop),
      .push_data(pc_q),
      .top_data(stack_top),
      .full(stack_full),
      .level(stack_index)
   );

   // ---------------- program counter
   always_comb begin
      pc_d = pc_q;
      if (last && !tbl_busy_q) begin
         if (take_irq) begin
            pc_d = vec;
         end else if (do_call || do_jump) begin
            pc_d = cmd.target;
         end else if (do_ret) begin
            pc_d = stack_top;
         end else if (pcl_wr) begin
            pc_d = {pc_q[PC_W-1:DATA_W], mem_wdata};
         end else begin
            // a true skip also steps here; the drop happens below
            pc_d = pc_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   assign instruction_pointer = pc_q;

   // ---------------- fetch pipeline
   // fetch of word pc_q overlaps execution of instr_q
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         instr_q <= '0;
      end else if (last && !tbl_busy_q) begin
         instr_q <= rom_data;
      end
   end

   // any reload or true skip turns the next slot into a dummy cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         instr_valid_q <= 1'b0;
      end else if (last && !tbl_busy_q) begin
         instr_valid_q <= !(take_irq || do_call || do_jump || do_ret
            || pcl_wr || do_skip);
      end
   end

   assign instr_word = instr_q;

   // ---------------- table read
   // second cycle borrows the rom port, so no fetch and no pc step then
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tbl_busy_q <= 1'b0;
         tbl_last_q <= 1'b0;
      end else if (last) begin
         tbl_busy_q <= do_tbl;
         if (do_tbl) begin
            tbl_last_q <= (cmd.op == OP_TABLE_READ_LAST_PAGE);
         end
      end
   end

   assign tbl_addr = {tbl_last_q ? LAST_PAGE : pc_q[PC_W-1:DATA_W], tbl_ptr_q};
   assign rom_addr = tbl_busy_q ? tbl_addr : pc_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tbl_wr_q <= 1'b0;
         tbl_wr_data_q <= '0;
         tbl_high_q <= TBL_HIGH_RESET;
      end else begin
         tbl_wr_q <= last && tbl_busy_q;
         if (last && tbl_busy_q) begin
            tbl_wr_data_q <= rom_data[DATA_W-1:0];
            tbl_high_q <= {2'b00, rom_data[ROM_W-1:DATA_W]};
         end
      end
   end

   assign tbl_wr = tbl_wr_q;
   assign tbl_wr_data = tbl_wr_data_q;

   // ---------------- register file
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tbl_ptr_q <= TBL_PTR_RESET;
      end else if (last && table_pointer_wr) begin
         tbl_ptr_q <= mem_wdata;
      end
   end

   // high byte has no write path; stack is not mapped at all
   always_comb begin
      mem_hit = 1'b1;
      case (mem_addr)
         OFS_PC_LOW: mem_rdata = pc_q[DATA_W-1:0];
         OFS_TBL_PTR: mem_rdata = tbl_ptr_q;
         OFS_TBL_HIGH: mem_rdata = tbl_high_q;
         default: begin
            mem_rdata = '0;
            mem_hit = 1'b0;
         end
      endcase
   end

   // ---------------- checks
   sequence s_cycle_gap;
      !cycle_end [*3] ##1 cycle_end;
   endsequence

   sequence s_dummy_slot;
      !exec_valid [*4];
   endsequence

   property p_reload_dummy;
      @(posedge clk) disable iff (!rstn)
      (last && !tbl_busy_q && (do_jump || do_call || do_ret || pcl_wr))
      |=> s_dummy_slot;
   endproperty

   a_phase_four: assert property (@(posedge clk) disable iff (!rstn) cycle_end |=> s_cycle_gap)
      else $error("instruction cycle is not four clocks");

   a_pc_step: assert property (@(posedge clk) disable iff (!rstn)
      (last && !tbl_busy_q && !busy_xfer && !take_irq) |=> pc_q == $past(pc_q) + 1'b1)
      else $error("counter did not step by one");

   a_skip_drop: assert property (@(posedge clk) disable iff (!rstn)
      (last && do_skip) |=> (pc_q == $past(pc_q) + 1'b1) ##0 s_dummy_slot)
      else $error("skip did not discard prefetched word");

   a_pcl_jump: assert property (@(posedge clk) disable iff (!rstn)
      (last && pcl_wr && !tbl_busy_q && !do_jump && !do_call && !do_ret)
      |=> pc_q == {$past(pc_q[10:8]), $past(mem_wdata)})
      else $error("low-byte write gave wrong counter");

   a_jump_target: assert property (@(posedge clk) disable iff (!rstn)
      (last && (do_jump || do_call) && !take_irq) |=> pc_q == $past(cmd.target))
      else $error("jump target not loaded");

   // expected vector follows the acknowledged line, not the vector mux
   a_vector_load: assert property (@(posedge clk)
      disable iff (!rstn) (|irq_ack) |=> pc_q == ($past(irq_ack[0]) ? VEC_EXT_A
         : $past(irq_ack[1]) ? VEC_EXT_B
         : $past(irq_ack[2]) ? VEC_TIMER
         : $past(irq_ack[3]) ? VEC_TIME_BASE
         : VEC_RTC))
      else $error("interrupt vector not loaded");

   // lowest pending request only, and only at the end of an instruction cycle
   a_ack_lowest: assert property (@(posedge clk)
      disable iff (!rstn) (|irq_ack)
      |-> cycle_end && !tbl_busy_q && irq_ack == (irq_req & (~irq_req + 5'h01)))
      else $error("interrupt acknowledge malformed");

   a_reload_dummy: assert property (p_reload_dummy)
      else $error("reload without dummy cycle");

   a_table_span: assert property (@(posedge clk) disable iff (!rstn)
      (last && do_tbl) |=> tbl_busy_q [*4] ##1 (!tbl_busy_q && tbl_wr))
      else $error("table read not two cycles");

   a_table_page: assert property (@(posedge clk) disable iff (!rstn)
      tbl_busy_q |-> rom_addr[10:8] == (tbl_last_q ? 3'h7 : pc_q[10:8])
         && rom_addr[7:0] == tbl_ptr_q)
      else $error("table page bits wrong");

   a_table_high: assert property (@(posedge clk) disable iff (!rstn)
      tbl_wr |-> tbl_high_q[7:6] == 2'b00 && tbl_high_q[5:0] == $past(rom_data[13:8]))
      else $error("table high byte wrong");

   a_full_hold: assert property (@(posedge clk) disable iff (!rstn)
      stack_full |-> irq_ack == '0)
      else $error("interrupt taken with full stack");

   a_call_push: assert property (@(posedge clk) disable iff (!rstn)
      (last && do_call && !take_irq) |=> stack_top == $past(pc_q))
      else $error("call did not push return address");

   a_ret_restore: assert property (@(posedge clk) disable iff (!rstn)
      (last && do_ret && !take_irq) |=> pc_q == $past(stack_top))
      else $error("return did not restore counter");

   a_stack_depth: assert property (@(posedge clk) disable iff (!rstn)
      stack_index <= 3'h4)
      else $error("stack index beyond four");
endmodule // pss_sequencer

// ---- test/pss_rom_decode_model.sv ----
// Purpose: program memory and decode logic at the far side of the sequencer
// Assumes: word bits 13..11 carry the op code, bits 10..0 the target
// Notes: data words decode as well, but the sequencer never executes them
`timescale 1ns/10ps
module pss_rom_decode_model (
   input wire logic [pss_pkg::PC_W-1:0] rom_addr,
   input wire logic [pss_pkg::ROM_W-1:0] instr_word,
   input wire logic skip_cond,
   output logic [pss_pkg::ROM_W-1:0] rom_data,
   output pss_pkg::pss_cmd_type cmd
);
   import pss_pkg::*;
   // a declaration value lands before any initial block, so the bench's program survives
   logic [ROM_W-1:0] words [ROM_WORDS] = '{default: 14'h0000};
   // combinational read, the sequencer samples it at cycle end
   assign rom_data = words[rom_addr];
   always_comb begin
      cmd.op = pss_op_type'(instr_word[13:11]);
      cmd.target = instr_word[10:0];
      cmd.skip_true = skip_cond;
   end
endmodule // pss_rom_decode_model

// ---- test/test_program_sequencer_stack.sv ----
// Purpose: self-checking bench for the program sequencer
// Assumes: inputs change on the falling edge only
// Notes: flow is checked through the counter seen in each execute slot
`timescale 1ns/10ps
module test_program_sequencer_stack;
   import pss_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [PC_W-1:0] rom_addr;
   logic [ROM_W-1:0] rom_data;
   logic [ROM_W-1:0] instr_word;
   logic exec_valid;
   logic cycle_end;
   pss_cmd_type cmd;
   logic [MEM_AW-1:0] mem_addr = 7'h00;
   logic mem_wr = 1'b0;
   logic [DATA_W-1:0] mem_wdata = 8'h00;
   logic [DATA_W-1:0] mem_rdata;
   logic mem_hit;
   logic tbl_wr;
   logic [DATA_W-1:0] tbl_wr_data;
   logic [IRQ_N-1:0] irq_req = 5'h00;
   logic [IRQ_N-1:0] irq_ack;
   logic [PC_W-1:0] instruction_pointer;
   logic stack_full;
   logic [STK_CNT_W-1:0] stack_index;
   logic skip_cond = 1'b1;
   int failures = 0;
   int compares = 0;
   int since = 0;

   always #2 clk = ~clk;

   pss_sequencer DUT (.clk(clk), .rstn(rstn), .rom_addr(rom_addr), .rom_data(rom_data),
      .instr_word(instr_word), .exec_valid(exec_valid), .cycle_end(cycle_end), .cmd(cmd),
      .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_hit(mem_hit), .tbl_wr(tbl_wr), .tbl_wr_data(tbl_wr_data), .irq_req(irq_req),
      .irq_ack(irq_ack), .instruction_pointer(instruction_pointer),
      .stack_full(stack_full), .stack_index(stack_index));

   pss_rom_decode_model far_side (.rom_addr(rom_addr), .instr_word(instr_word),
      .skip_cond(skip_cond), .rom_data(rom_data), .cmd(cmd));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic [ROM_W-1:0] w(input pss_op_type op, input logic [PC_W-1:0] t);
      return {op, t};
   endfunction

   task automatic do_reset();
      @(negedge clk);
      rstn = 1'b0;
      repeat (6) @(negedge clk);
      chk(instruction_pointer, 16'h0000, "pc in reset");
      chk(stack_index, 16'h0000, "stack index in reset");
      rstn = 1'b1;
   endtask

   // waits for the next execute slot, counting the dummy slots on the way
   task automatic next_exec(input logic [PC_W-1:0] addr, input int gap);
      int dummies;
      int n;
      dummies = 0;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         if (cycle_end === 1'b1 && exec_valid === 1'b1) break;
         if (cycle_end === 1'b1) dummies++;
      end
      chk(16'(n < 40), 16'h0001, "execute slot reached");
      chk({5'h00, addr + 11'h001}, instruction_pointer, "counter after fetch");
      chk(instr_word, far_side.words[addr], "executed word");
      chk(16'(dummies), 16'(gap), "dummy slots");
   endtask

   // called in a cycle_end slot so the write lands at that edge
   task automatic wr(input logic [MEM_AW-1:0] a, input logic [DATA_W-1:0] d);
      mem_addr = a;
      mem_wdata = d;
      mem_wr = 1'b1;
      @(negedge clk);
      mem_wr = 1'b0;
   endtask

   task automatic rd(input logic [MEM_AW-1:0] a, input logic [DATA_W-1:0] d, input logic hit);
      mem_addr = a;
      #1;
      chk(mem_rdata, d, "register read");
      chk(mem_hit, hit, "register hit");
      @(negedge clk);
   endtask

   task automatic wait_tbl(input logic [PC_W-1:0] a, input logic [7:0] lo, input logic [7:0] hi);
      int ends;
      int n;
      ends = 0;
      for (n = 0; n < 20 && tbl_wr !== 1'b1; n++) begin
         @(negedge clk);
         if (exec_valid === 1'b0) chk(rom_addr, a, "table address");
         if (cycle_end === 1'b1) ends++;
      end
      chk(tbl_wr_data, lo, "table low byte");
      chk(16'(ends), 16'h0001, "table read length");
      rd(OFS_TBL_HIGH, hi, 1'b1);
   endtask

   task automatic irq_test();
      logic [PC_W-1:0] vec [5];
      int i;
      int n;
      vec = '{VEC_EXT_A, VEC_EXT_B, VEC_TIMER, VEC_TIME_BASE, VEC_RTC};
      irq_req = 5'h1F;
      #1;
      for (i = 0; i < 5; i++) begin
         for (n = 0; n < 60 && !(cycle_end === 1'b1 && irq_ack !== 5'h00); n++) @(negedge clk);
         chk(irq_ack, 16'(5'h01 << i), "acknowledge order");
         chk(stack_index, 16'((i < 4) ? i : 3), "depth at acknowledge");
         @(negedge clk);
         irq_req[i] = 1'b0;
         chk(instruction_pointer, vec[i], "vector");
         chk(stack_index, 16'((i < 4) ? i + 1 : 4), "push on acknowledge");
      end
      $display("interrupt test done");
   endtask

   // every instruction cycle must last four clocks
   always @(negedge clk) begin
      if (rstn !== 1'b1) begin
         since = 0;
      end else if (cycle_end === 1'b1) begin
         if (since > 0) chk(16'(since), 16'h0004, "instruction cycle length");
         since = 1;
      end else if (since > 0) begin
         since++;
      end
   end

   initial begin
      #40000;
      failures++;
      $display("FAIL %0t watchdog expired", $time);
      give_verdict();
   end

   initial begin
      far_side.words[11'h004] = w(OP_INTERRUPT_RETURN, 11'h000);
      far_side.words[11'h008] = w(OP_INTERRUPT_RETURN, 11'h000);
      far_side.words[11'h00C] = w(OP_INTERRUPT_RETURN, 11'h000);
      far_side.words[11'h010] = w(OP_INTERRUPT_RETURN, 11'h000);
      far_side.words[11'h014] = w(OP_INTERRUPT_RETURN, 11'h000);
      far_side.words[11'h001] = w(OP_JUMP, 11'h123);
      far_side.words[11'h123] = w(OP_CALL, 11'h200);
      far_side.words[11'h200] = w(OP_CALL, 11'h300);
      far_side.words[11'h300] = w(OP_CALL, 11'h400);
      far_side.words[11'h400] = w(OP_CALL, 11'h500);
      far_side.words[11'h500] = w(OP_CALL, 11'h600);
      far_side.words[11'h600] = w(OP_SUBROUTINE_RETURN, 11'h000);
      far_side.words[11'h501] = w(OP_SUBROUTINE_RETURN, 11'h000);
      far_side.words[11'h401] = w(OP_SUBROUTINE_RETURN, 11'h000);
      far_side.words[11'h301] = w(OP_SUBROUTINE_RETURN, 11'h000);
      far_side.words[11'h201] = w(OP_SKIP, 11'h000);
      far_side.words[11'h202] = w(OP_JUMP, 11'h7FF);
      far_side.words[11'h203] = w(OP_TABLE_READ_CURRENT_PAGE, 11'h000);
      far_side.words[11'h204] = w(OP_TABLE_READ_LAST_PAGE, 11'h000);
      far_side.words[11'h245] = 14'h2ABC;
      far_side.words[11'h745] = 14'h3F5A;
      far_side.words[11'h280] = w(OP_SKIP, 11'h000);
      do_reset();
      next_exec(11'h000, 1);
      irq_test();
      do_reset();
      next_exec(11'h000, 1);
      wr(OFS_TBL_PTR, 8'h45);
      rd(OFS_TBL_PTR, 8'h45, 1'b1);
      next_exec(11'h001, 0);
      next_exec(11'h123, 1);
      next_exec(11'h200, 1);
      next_exec(11'h300, 1);
      next_exec(11'h400, 1);
      next_exec(11'h500, 1);
      chk(stack_full, 16'h0001, "stack full");
      next_exec(11'h600, 1);
      chk(stack_index, 16'h0004, "depth after overflow");
      next_exec(11'h501, 1);
      next_exec(11'h401, 1);
      next_exec(11'h301, 1);
      next_exec(11'h201, 1);
      chk(stack_index, 16'h0000, "oldest entry lost");
      next_exec(11'h203, 1);
      wait_tbl(11'h245, 8'hBC, 8'h2A);
      next_exec(11'h204, 0);
      wait_tbl(11'h745, 8'h5A, 8'h3F);
      next_exec(11'h205, 0);
      wr(OFS_TBL_HIGH, 8'hFF);
      rd(OFS_TBL_HIGH, 8'h3F, 1'b1);
      next_exec(11'h206, 0);
      wr(OFS_PC_LOW, 8'h80);
      skip_cond = 1'b0;
      next_exec(11'h280, 1);
      next_exec(11'h281, 0);
      rd(OFS_PC_LOW, 8'h82, 1'b1);
      rd(7'h09, 8'h00, 1'b0);
      $display("program flow test done");
      give_verdict();
   end
endmodule // test_program_sequencer_stack
